// *** core/dpcfg_regs.sv ***
`timescale 1ns/1ps
`include "dpcfg_params.svh"
// What this block does
// - Writing one to bit 0 of the transfer register copies the stored free-run tuning word into the working word.
// - The transfer strobe clears itself after the copy, so it always reads back zero.
// - In free-run mode the working word follows the stored free-run word without any strobe.
// - The lower pull-in limit is 24 bits over three bytes, least significant byte lowest.
// - The upper pull-in limit is 24 bits over the next three bytes, least significant byte lowest.
// - After reset the lower limit is zero and the upper limit all ones.
// - The 16-bit open-loop phase offset is stored low byte first and resets to zero.
// - The 40-bit fixed lock offset is stored low byte first over five bytes and resets to zero.
// - The 16-bit lock offset step size resets to one thousand.
// - The 16-bit slew limit resets to zero, which disables the limiter.
// - The 24-bit history period is stored low byte first and resets to thirty thousand.
// - With no history on entering holdover, bit 4 picks the free-run word at zero or the last loop word at one.
// - On a reference switch, bit 3 at zero clears the history and at one keeps it.
// - The three-bit averaging mode field holds zero to seven and resets to zero.
// - The free-run tuning word is 48 bits over six bytes, least significant byte first.
module dpcfg_regs #(
    parameter int TW_W = 48
) (
    // Clock and reset.
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // APB slave.
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [13:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Loop state from the tuning word logic.
    input  wire logic                     free_run_mode,
    input  wire logic                     holdover_entry,
    input  wire logic                     history_valid,
    input  wire logic                     ref_switch,
    input  wire logic [TW_W-1:0]          last_loop_tw,
    // Outputs to the loop logic.
    output logic      [TW_W-1:0]          working_tw,
    output logic      [TW_W-1:0]          holdover_tw,
    output logic                          history_clear,
    output dpcfg_pkg::dpcfg_settings_s    settings
);

    localparam int NB = `DPCFG_NUM_BYTES;

    // Reset values of the multi-byte fields, held as constants so that single bytes can be picked out.
    localparam logic [47:0] RST_TW    = `DPCFG_RST_FREE_RUN_TW;
    localparam logic [23:0] RST_LOWER = `DPCFG_RST_PULL_IN_LOWER;
    localparam logic [23:0] RST_UPPER = `DPCFG_RST_PULL_IN_UPPER;
    localparam logic [15:0] RST_PHASE = `DPCFG_RST_OPEN_LOOP_PHASE;
    localparam logic [39:0] RST_FIXED = `DPCFG_RST_FIXED_LOCK_OFFSET;
    localparam logic [15:0] RST_STEP  = `DPCFG_RST_LOCK_STEP;
    localparam logic [15:0] RST_SLEW  = `DPCFG_RST_SLEW_LIMIT;
    localparam logic [23:0] RST_HIST  = `DPCFG_RST_HISTORY_PERIOD;
    localparam logic [7:0]  RST_MODE  = `DPCFG_RST_HISTORY_MODE;

    // Positions inside the byte image, counted from the first free-run byte.
    localparam logic [11:0] REL_TRANSFER = `DPCFG_IDX_TW_TRANSFER - `DPCFG_IDX_FREE_RUN_TW0;
    localparam logic [11:0] REL_MODE     = `DPCFG_IDX_HISTORY_MODE - `DPCFG_IDX_FREE_RUN_TW0;
    localparam logic [11:0] REL_STATUS   = `DPCFG_IDX_LOOP_STATUS - `DPCFG_IDX_FREE_RUN_TW0;

    // Reset image of the byte space, little endian, so every multi-byte field sits low byte first.
    // Keeping it as a constant table lets the asynchronous reset branch load constants only.
    localparam logic [7:0] RST_IMG [NB] = '{
        RST_TW[7:0],        // Free-run word, byte 0.
        RST_TW[15:8],       // Free-run word, byte 1.
        RST_TW[23:16],      // Free-run word, byte 2.
        RST_TW[31:24],      // Free-run word, byte 3.
        RST_TW[39:32],      // Free-run word, byte 4.
        RST_TW[47:40],      // Free-run word, byte 5.
        8'h00,              // Transfer strobe, never stored.
        RST_LOWER[7:0],     // Lower pull-in limit, byte 0.
        RST_LOWER[15:8],    // Lower pull-in limit, byte 1.
        RST_LOWER[23:16],   // Lower pull-in limit, byte 2.
        RST_UPPER[7:0],     // Upper pull-in limit, byte 0.
        RST_UPPER[15:8],    // Upper pull-in limit, byte 1.
        RST_UPPER[23:16],   // Upper pull-in limit, byte 2.
        RST_PHASE[7:0],     // Open-loop phase offset, byte 0.
        RST_PHASE[15:8],    // Open-loop phase offset, byte 1.
        RST_FIXED[7:0],     // Fixed lock offset, byte 0.
        RST_FIXED[15:8],    // Fixed lock offset, byte 1.
        RST_FIXED[23:16],   // Fixed lock offset, byte 2.
        RST_FIXED[31:24],   // Fixed lock offset, byte 3.
        RST_FIXED[39:32],   // Fixed lock offset, byte 4.
        RST_STEP[7:0],      // Lock offset step, byte 0.
        RST_STEP[15:8],     // Lock offset step, byte 1.
        RST_SLEW[7:0],      // Slew limit, byte 0.
        RST_SLEW[15:8],     // Slew limit, byte 1.
        RST_HIST[7:0],      // History period, byte 0.
        RST_HIST[15:8],     // History period, byte 1.
        RST_HIST[23:16],    // History period, byte 2.
        RST_MODE            // History mode controls.
    };

    // Byte image of the configuration space from index 0x300 upward.
    logic [7:0]      cfg_r [NB];
    logic [11:0]     idx;
    logic [11:0]     rel;
    logic            in_map;
    logic            access;
    logic            wr_en;
    logic            transfer_req;
    logic [TW_W-1:0] free_run_tw;
    logic [7:0]      rd_byte;

    // Registered copies of each field, packed into the settings bundle below.
    logic [23:0]     lower_r;
    logic [23:0]     upper_r;
    logic [15:0]     phase_r;
    logic [39:0]     fixed_r;
    logic [15:0]     step_r;
    logic [15:0]     slew_r;
    logic [23:0]     hist_r;
    logic            fallback_r;
    logic            persist_r;
    logic [2:0]      avg_r;

    // The word address carries the byte index; the low two address bits are ignored.
    assign idx    = paddr[13:2];
    assign rel    = idx - `DPCFG_IDX_FREE_RUN_TW0;
    assign in_map = (idx >= `DPCFG_IDX_FREE_RUN_TW0) && (idx <= `DPCFG_IDX_LOOP_STATUS);
    assign access = psel && penable;

    // A write lands only at the edge where the access phase meets a high ready.
    // Writing once per transfer keeps the strobe from firing twice for one bus write.
    assign wr_en  = access && pready && pwrite && in_map;

    // Byte storage; the transfer byte and status byte are never stored; the transfer byte reads zero and the status byte shows loop state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NB; i++) begin
                cfg_r[i] <= RST_IMG[i];
            end
        end else if (wr_en) begin
            if (rel == REL_MODE) begin
                cfg_r[rel[4:0]] <= {3'h0, pwdata[4:0]};
            end else if (rel != REL_TRANSFER && rel != REL_STATUS) begin
                cfg_r[rel[4:0]] <= pwdata[7:0];
            end
        end
    end

    // Free-run word gathered low byte first.
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            free_run_tw[8*i +: 8] = cfg_r[i];
        end
    end

    // A one in bit 0 of the transfer register raises a single-cycle request.
    // The strobe is never stored, so it clears itself and software never writes zero to it.
    assign transfer_req = wr_en && (rel == REL_TRANSFER) && pwdata[`DPCFG_TRANSFER_BIT];

    // Working word: copied on request, and tracks the stored word in free run.
    // In free run the copy happens every cycle, so the word lags a byte write by one cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            working_tw <= '0;
        end else if (transfer_req || free_run_mode) begin
            working_tw <= free_run_tw;
        end
    end

    // Holdover source chosen when holdover starts without history.
    // With history present the loop logic supplies its own average, so nothing is loaded here.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            holdover_tw <= '0;
        end else if (holdover_entry && !history_valid) begin
            holdover_tw <= cfg_r[REL_MODE[4:0]][`DPCFG_FALLBACK_BIT] ? last_loop_tw : free_run_tw;
        end
    end

    // History clear pulse on a reference switch unless history is persistent.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            history_clear <= 1'b0;
        end else begin
            history_clear <= ref_switch && !cfg_r[REL_MODE[4:0]][`DPCFG_PERSIST_BIT];
        end
    end

    // Lower pull-in limit, low byte at the lowest index.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lower_r <= RST_LOWER;
        end else begin
            lower_r <= {cfg_r[9], cfg_r[8], cfg_r[7]};
        end
    end

    // Upper pull-in limit, low byte at the lowest index.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_r <= RST_UPPER;
        end else begin
            upper_r <= {cfg_r[12], cfg_r[11], cfg_r[10]};
        end
    end

    // Open-loop synthesizer phase offset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= RST_PHASE;
        end else begin
            phase_r <= {cfg_r[14], cfg_r[13]};
        end
    end

    // Fixed closed-loop lock offset over five bytes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fixed_r <= RST_FIXED;
        end else begin
            fixed_r <= {cfg_r[19], cfg_r[18], cfg_r[17], cfg_r[16], cfg_r[15]};
        end
    end

    // Incremental lock offset step size.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_r <= RST_STEP;
        end else begin
            step_r <= {cfg_r[21], cfg_r[20]};
        end
    end

    // Phase slew limit; zero leaves the limiter off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slew_r <= RST_SLEW;
        end else begin
            slew_r <= {cfg_r[23], cfg_r[22]};
        end
    end

    // History period. A zero period is left to software to avoid; the hardware passes it through,
    // since clamping it here would hide a programming error from the loop logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_r <= RST_HIST;
        end else begin
            hist_r <= {cfg_r[26], cfg_r[25], cfg_r[24]};
        end
    end

    // Holdover fallback selection bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fallback_r <= RST_MODE[`DPCFG_FALLBACK_BIT];
        end else begin
            fallback_r <= cfg_r[REL_MODE[4:0]][`DPCFG_FALLBACK_BIT];
        end
    end

    // Persistent history bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            persist_r <= RST_MODE[`DPCFG_PERSIST_BIT];
        end else begin
            persist_r <= cfg_r[REL_MODE[4:0]][`DPCFG_PERSIST_BIT];
        end
    end

    // Averaging mode field; every three-bit code is legal.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            avg_r <= RST_MODE[`DPCFG_AVG_MSB:0];
        end else begin
            avg_r <= cfg_r[REL_MODE[4:0]][`DPCFG_AVG_MSB:0];
        end
    end

    // The bundle is pure wiring of flip-flops, one cycle behind the byte image.
    assign settings = '{pull_in_lower:     lower_r,
                        pull_in_upper:     upper_r,
                        open_loop_phase:   phase_r,
                        fixed_lock_offset: fixed_r,
                        lock_step:         step_r,
                        slew_limit:        slew_r,
                        history_period:    hist_r,
                        fallback_last_tw:  fallback_r,
                        persist_history:   persist_r,
                        avg_mode:          avg_r};

    // Read byte: the status index shows loop state; the transfer byte reads zero.
    always_comb begin
        rd_byte = 8'h00;
        if (in_map) begin
            if (rel == REL_STATUS) begin
                rd_byte = {6'h00, history_valid, free_run_mode};
            end else if (rel != REL_TRANSFER) begin
                rd_byte = cfg_r[rel[4:0]];
            end
        end
    end

    // APB answer: one wait state, so pready and prdata come from flip-flops.
    // Ready rises after the first access cycle and falls again at once, so it is a single pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
        end else begin
            pready  <= access && !pready;
        end
    end

    // Read data is captured in the first access cycle and stands while ready is high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
        end else begin
            prdata  <= {24'h000000, rd_byte};
        end
    end

    // An index outside the map answers with an error and stores nothing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= access && !pready && !in_map;
        end
    end

endmodule

// *** core/dpcfg_params.svh ***
`ifndef DPCFG_PARAMS_SVH
`define DPCFG_PARAMS_SVH

// Indices of the configuration bytes; APB address is four times the index.
`define DPCFG_IDX_FREE_RUN_TW0        12'h300
`define DPCFG_IDX_TW_TRANSFER         12'h306
`define DPCFG_IDX_PULL_IN_LOWER0      12'h307
`define DPCFG_IDX_PULL_IN_UPPER0      12'h30a
`define DPCFG_IDX_OPEN_LOOP_PHASE0    12'h30d
`define DPCFG_IDX_FIXED_LOCK_OFFSET0  12'h30f
`define DPCFG_IDX_LOCK_STEP0          12'h314
`define DPCFG_IDX_SLEW_LIMIT0         12'h316
`define DPCFG_IDX_HISTORY_PERIOD0     12'h318
`define DPCFG_IDX_HISTORY_MODE        12'h31b
`define DPCFG_IDX_LOOP_STATUS         12'h31c

// Number of bytes in the configuration image.
`define DPCFG_NUM_BYTES               28

// Field positions.
`define DPCFG_TRANSFER_BIT            0
`define DPCFG_FALLBACK_BIT            4
`define DPCFG_PERSIST_BIT             3
`define DPCFG_AVG_MSB                 2

// Reset values.
`define DPCFG_RST_FREE_RUN_TW         48'h000000000000
`define DPCFG_RST_PULL_IN_LOWER       24'h000000
`define DPCFG_RST_PULL_IN_UPPER       24'hffffff
`define DPCFG_RST_OPEN_LOOP_PHASE     16'h0000
`define DPCFG_RST_FIXED_LOCK_OFFSET   40'h0000000000
`define DPCFG_RST_LOCK_STEP           16'h03e8
`define DPCFG_RST_SLEW_LIMIT          16'h0000
`define DPCFG_RST_HISTORY_PERIOD      24'h007530
`define DPCFG_RST_HISTORY_MODE        8'h00

`endif

// *** core/dpcfg_pkg.sv ***
package dpcfg_pkg;

    // Settings handed to the loop logic as one bundle.
    typedef struct packed {
        logic [23:0] pull_in_lower;
        logic [23:0] pull_in_upper;
        logic [15:0] open_loop_phase;
        logic [39:0] fixed_lock_offset;
        logic [15:0] lock_step;
        logic [15:0] slew_limit;
        logic [23:0] history_period;
        logic        fallback_last_tw;
        logic        persist_history;
        logic [2:0]  avg_mode;
    } dpcfg_settings_s;

endpackage

// *** testbench/dpcfg_regs_monitor.sv ***
`timescale 1ns/1ps
`include "dpcfg_params.svh"
module dpcfg_regs_monitor #(
    parameter int TW_W = 48
) (
    // Clock and reset.
    input wire logic                       pclk,
    input wire logic                       presetn,
    // APB slave side.
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [13:0]                paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    // Loop side.
    input wire logic                       free_run_mode,
    input wire logic                       holdover_entry,
    input wire logic                       history_valid,
    input wire logic                       ref_switch,
    input wire logic [TW_W-1:0]            working_tw,
    input wire logic [TW_W-1:0]            holdover_tw,
    input wire logic                       history_clear,
    input wire dpcfg_pkg::dpcfg_settings_s settings
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A write of one to the strobe bit; the only legal cause of a copy outside free-run.
    wire xfer = psel && penable && pwrite && paddr == {`DPCFG_IDX_TW_TRANSFER, 2'b00} && pwdata[0];
    sequence s_wait; psel && penable && !pready; endsequence
    property p_rdy; s_wait |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("late ready");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_idle; !(psel && penable) |=> !pready; endproperty
    a_idle: assert property (p_idle) else $error("stray ready");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_zero; pready |-> prdata[31:8] == 24'h000000; endproperty
    a_zero: assert property (p_zero) else $error("upper read bits set");
    property p_tw; !$stable(working_tw) |-> $past(xfer) || $past(free_run_mode) || $past(free_run_mode, 2); endproperty
    a_tw: assert property (p_tw) else $error("working word moved");
    property p_clr; history_clear == ($past(ref_switch) && !$past(settings.persist_history)); endproperty
    a_clr: assert property (p_clr) else $error("history clear wrong");
    property p_hold; !$stable(holdover_tw) |-> $past(holdover_entry && !history_valid); endproperty
    a_hold: assert property (p_hold) else $error("holdover word moved");
endmodule

// *** testbench/dpcfg_regs_tb.sv ***
`timescale 1ns/1ps
module dpcfg_regs_tb;
    logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic                       free_run_mode, holdover_entry, history_valid, ref_switch, history_clear;
    logic [13:0]                paddr;
    logic [31:0]                pwdata, prdata, rd;
    logic [47:0]                last_loop_tw, working_tw, holdover_tw;
    dpcfg_pkg::dpcfg_settings_s st;
    int                         m[28], n_fail, num_checks, seed, i, j, k;
    dpcfg_regs #(.TW_W(48)) dpcfg_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .free_run_mode(free_run_mode), .holdover_entry(holdover_entry), .history_valid(history_valid),
        .ref_switch(ref_switch), .last_loop_tw(last_loop_tw), .working_tw(working_tw),
        .holdover_tw(holdover_tw), .history_clear(history_clear), .settings(st));
    // Free-running clock at 25 MHz.
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    // Assemble a little-endian field from the byte model.
    function automatic logic [47:0] fw(int b, int n);
        fw = 0;
        for (int q = n - 1; q >= 0; q--) fw = (fw << 8) | 48'(m[b + q]);
    endfunction
    task automatic chk(input logic [47:0] g, input logic [47:0] x);
        num_checks++;
        if (g !== x) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One APB transfer; the request stands until ready is sampled high, then an idle cycle follows.
    task automatic apb(input logic w, input int idx, input logic [7:0] d);
        int t;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 14'((idx + 'h300) * 4);
        pwdata <= {24'($random(seed)), d};
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (t >= 20) begin
            n_fail++;
            conclude();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // The strobe byte stores nothing, and unused mode bits are dropped.
    task automatic wr(input int idx, input logic [7:0] d);
        apb(1'b1, idx, d);
        if (idx != 6) m[idx] = int'(d & (idx == 27 ? 8'h1f : 8'hff));
    endtask
    task automatic rdc(input int idx);
        apb(1'b0, idx, 8'h00);
        chk({16'h0000, rd}, idx == 6 ? 48'h0 : 48'(m[idx]));
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        conclude();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {free_run_mode, holdover_entry, history_valid, ref_switch, last_loop_tw} = '0;
        seed = 3425;
        m = '{10: 'hff, 11: 'hff, 12: 'hff, 20: 'he8, 21: 'h03, 24: 'h30, 25: 'h75, default: 0};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 28; i++) rdc(i);
        for (i = 0; i < 28; i++) if (i != 6) wr(i, 8'($random(seed)) | 8'(i == 24));
        for (i = 0; i < 28; i++) rdc(i);
        chk(st.pull_in_lower, fw(7, 3));
        chk(st.pull_in_upper, fw(10, 3));
        chk(st.fixed_lock_offset, fw(15, 5));
        chk(st.avg_mode, fw(27, 1) & 48'h7);
        chk(st.open_loop_phase, fw(13, 2));
        chk(st.lock_step, fw(20, 2));
        chk(st.slew_limit, fw(22, 2));
        chk(st.history_period, fw(24, 3));
        wr(6, 8'h01);
        chk(working_tw, fw(0, 6));
        free_run_mode <= 1'b1;
        for (i = 0; i < 6; i++) wr(i, 8'($random(seed)));
        for (k = 0; k < 8 && working_tw !== fw(0, 6); k++) @(posedge pclk);
        chk(working_tw, fw(0, 6));
        free_run_mode <= 1'b0;
        // Holdover fallback and reference switch for both settings of each mode bit.
        for (j = 0; j < 2; j++) begin
            wr(27, {3'h0, j[0], 4'h0});
            last_loop_tw <= {16'($random(seed)), 32'($random(seed))};
            holdover_entry <= 1'b1;
            @(posedge pclk);
            holdover_entry <= 1'b0;
            @(posedge pclk);
            chk(holdover_tw, j ? last_loop_tw : fw(0, 6));
            wr(27, {4'h0, j[0], 3'h5});
            ref_switch <= 1'b1;
            @(posedge pclk);
            ref_switch <= 1'b0;
            @(posedge pclk);
            chk({47'h0, history_clear}, 48'(j == 0));
        end
        chk({47'h0, st.persist_history}, 48'(m[27][3]));
        chk({47'h0, st.fallback_last_tw}, 48'(m[27][4]));
        apb(1'b0, 'h1d, 8'h00);
        chk({47'h0, e}, 48'h1);
        conclude();
    end
endmodule
bind dpcfg_regs dpcfg_regs_monitor #(.TW_W(TW_W)) dpcfg_regs_monitor_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .free_run_mode(free_run_mode), .holdover_entry(holdover_entry),
    .history_valid(history_valid), .ref_switch(ref_switch), .working_tw(working_tw),
    .holdover_tw(holdover_tw), .history_clear(history_clear), .settings(settings));
